// ---- verilog/acc_pkg.sv ----
// Constants for the analog converter control block.
// Assumes byte addressing on the register bus, one aligned word per register.
package acc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_RESULT_LOW  = 8'h78;
  localparam logic [7:0] IDX_RESULT_HIGH = 8'h79;
  localparam logic [7:0] IDX_CTRL_STATUS = 8'h7a;
  localparam logic [7:0] IDX_TRIG_CONFIG = 8'h7b;
  localparam logic [7:0] IDX_INPUT_SEL   = 8'h7c;
  localparam logic [7:0] IDX_DIG_DISABLE = 8'h7e;

  ////////////////////////////////////////////////////////////////////////////
  // Control and status field positions
  localparam int CS_ENABLE  = 7;
  localparam int CS_START   = 6;
  localparam int CS_AUTO    = 5;
  localparam int CS_DONE    = 4;
  localparam int CS_IRQ_EN  = 3;
  localparam int CS_DIV_MSB = 2;

  // Input selection field positions
  localparam int IS_REF_MSB  = 7;
  localparam int IS_REF_LSB  = 6;
  localparam int IS_LEFT     = 5;
  localparam int IS_CH_MSB   = 3;

  // Reference and channel codes
  localparam logic [1:0] REF_EXTERNAL = 2'h0;
  localparam logic [1:0] REF_SUPPLY   = 2'h1;
  localparam logic [1:0] REF_RESERVED = 2'h2;
  localparam logic [1:0] REF_BANDGAP  = 2'h3;
  localparam logic [3:0] CH_LAST_PIN  = 4'h7;
  localparam logic [3:0] CH_BANDGAP   = 4'he;
  localparam logic [3:0] CH_GROUND    = 4'hf;

  // Trigger source codes
  localparam logic [2:0] TRIG_FREE_RUN = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and timing in converter clock cycles
  localparam logic [7:0] RESET_BYTE    = 8'h00;
  localparam logic [9:0] RESET_RESULT  = 10'h000;
  localparam logic [4:0] CYC_FIRST     = 5'd25;
  localparam logic [4:0] CYC_NORMAL    = 5'd13;
  localparam int         NUM_DIG_PINS  = 6;
  localparam int         NUM_TRIG_SRC  = 7;

endpackage : acc_pkg

// ---- verilog/acc_converter_control.sv ----
// Digital control of a 10-bit successive-approximation converter.
// Assumes an Avalon-MM master, an analog front end that presents the code of
// the applied channel at all times, and trigger flags synchronous to core_clk.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Reference field picks external, supply or bandgap
// - Reference and channel changes apply next cycle when idle, after completion when busy
// - Justify bit reshapes presented result at once
// - Bit 4 of input select reads zero
// - Channel codes: pins 0-7, bandgap, ground
// - Enable powers converter; clearing aborts conversion
// - Writing start begins a conversion
// - First conversion 25 cycles, later ones 13
// - Start reads one while busy; zero ignored
// - Auto trigger starts on selected rising edge
// - Done flag set on update; gated interrupt request
// - Done flag clears on vector or write one
// - Prescaler divides by 2 up to 128
// - Result byte layout per justification
// - Low byte read locks result until high read
// - Result code is input over reference times 1024
// - Trigger source ignored unless auto trigger set
// - Switching to a set source is an edge
// - Selecting free running alone triggers nothing
// - Trigger code map of eight sources
// - Disable bits gate the digital pin inputs
module acc_converter_control (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Avalon-MM register slave
  input  wire logic [9:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWritedata,
  input  wire logic [3:0]  avsByteenable,
  output logic      [31:0] avsReaddata,
  output logic             avsWaitrequest,
  // Analog front end
  input  wire logic [9:0]  analogCode,
  output logic             converterPower,
  output logic [1:0]       appliedReference,
  output logic [3:0]       appliedChannel,
  // Triggers and interrupt
  input  wire logic [6:0]  triggerFlags,
  input  wire logic        globalIrqEnable,
  input  wire logic        doneVectorTaken,
  output logic             doneIrq,
  // Digital pin gating
  input  wire logic [5:0]  portPinRaw,
  output logic [5:0]       pinBufferDisable,
  output logic [5:0]       portPinRead
);

  //////////////////////////////////////////////////////////////////////////////
  // Mask of prescaler bits that must be all ones for one converter tick
  function automatic logic [6:0] divMask(input logic [2:0] code);
    logic [6:0] m;
    m = 7'h01;
    if (code > 3'h1) begin
      m = 7'(({7'h00, 1'b1} << code) - 8'h01);
    end
    return m;
  endfunction : divMask

  // Register index of a byte address
  function automatic logic [7:0] regIndex(input logic [9:0] addr);
    return addr[9:2];
  endfunction : regIndex

  //////////////////////////////////////////////////////////////////////////////
  // State
  logic       ackQ;
  logic [31:0] readdataQ;
  logic       enQ, autoQ, flagQ, ieQ;
  logic [2:0] divQ;
  logic [1:0] refQ;
  logic       leftQ;
  logic [3:0] chQ;
  logic [2:0] trigSelQ;
  logic [5:0] didrQ;
  logic       busyQ, initDoneQ, lockQ, trigPrevQ;
  logic [4:0] cycLeftQ;
  logic [6:0] prescQ;
  logic [9:0] resultQ;
  logic [1:0] applRefQ;
  logic [3:0] applChQ;

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode; one wait cycle, answer on the second cycle
  wire        busReq     = avsRead | avsWrite;
  wire        accept     = busReq & ackQ;
  wire [7:0]  idx        = regIndex(avsAddress);
  wire        wrLane     = avsWrite & accept & avsByteenable[0];
  wire [7:0]  wdata      = avsWritedata[7:0];
  wire        csWrite    = wrLane & (idx == acc_pkg::IDX_CTRL_STATUS);
  wire        isWrite    = wrLane & (idx == acc_pkg::IDX_INPUT_SEL);
  wire        tsWrite    = wrLane & (idx == acc_pkg::IDX_TRIG_CONFIG);
  wire        ddWrite    = wrLane & (idx == acc_pkg::IDX_DIG_DISABLE);
  wire        lowRead    = avsRead & accept & (idx == acc_pkg::IDX_RESULT_LOW);
  wire        highRead   = avsRead & accept & (idx == acc_pkg::IDX_RESULT_HIGH);

  assign avsWaitrequest = busReq & ~ackQ;
  assign avsReaddata    = readdataQ;

  //////////////////////////////////////////////////////////////////////////////
  // Presented result, justification follows the live bit
  wire [7:0] resHigh = leftQ ? resultQ[9:2] : {6'h00, resultQ[9:8]};
  wire [7:0] resLow  = leftQ ? {resultQ[1:0], 6'h00} : resultQ[7:0];

  wire [7:0] csRead  = {enQ, busyQ, autoQ, flagQ, ieQ, divQ};
  wire [7:0] isRead  = {refQ, leftQ, 1'b0, chQ};
  wire [7:0] tsRead  = {5'h00, trigSelQ};
  wire [7:0] ddRead  = {2'h0, didrQ};

  logic [7:0] rdByte;
  always_comb begin
    unique case (idx)
      acc_pkg::IDX_RESULT_LOW:  rdByte = resLow;
      acc_pkg::IDX_RESULT_HIGH: rdByte = resHigh;
      acc_pkg::IDX_CTRL_STATUS: rdByte = csRead;
      acc_pkg::IDX_INPUT_SEL:   rdByte = isRead;
      acc_pkg::IDX_TRIG_CONFIG: rdByte = tsRead;
      acc_pkg::IDX_DIG_DISABLE: rdByte = ddRead;
      default:                  rdByte = acc_pkg::RESET_BYTE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ackQ      <= 1'b0;
      readdataQ <= 32'h0000_0000;
    end else begin
      ackQ      <= busReq & ~ackQ;
      readdataQ <= (avsRead & ~ackQ) ? {24'h00_0000, rdByte} : readdataQ;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Enable, prescaler and converter tick
  wire enD     = csWrite ? wdata[acc_pkg::CS_ENABLE] : enQ;
  wire [6:0] mask = divMask(divQ);
  wire adcTick = enQ & ((prescQ & mask) == mask);

  //////////////////////////////////////////////////////////////////////////////
  // Trigger selection; free running uses completion, not the done flag
  // Code 0 owns no flag, so free running never feeds the edge detector
  wire [7:0] trigVec = {triggerFlags, 1'b0};
  wire convDone  = busyQ & adcTick & (cycLeftQ == 5'd1);
  wire srcFlag   = trigVec[trigSelQ];
  wire freeRun   = (trigSelQ == acc_pkg::TRIG_FREE_RUN);
  wire srcEdge   = ~freeRun & srcFlag & ~trigPrevQ;
  wire autoStart = enQ & autoQ & (freeRun ? convDone : srcEdge);
  wire swStart   = csWrite & wdata[acc_pkg::CS_START];
  wire canStart  = ~busyQ | convDone;
  wire startConv = enD & canStart & (swStart | autoStart);
  wire updResult = convDone & ~lockQ;

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      enQ      <= 1'b0;
      autoQ    <= 1'b0;
      ieQ      <= 1'b0;
      divQ     <= 3'h0;
      refQ     <= acc_pkg::REF_EXTERNAL;
      leftQ    <= 1'b0;
      chQ      <= 4'h0;
      trigSelQ <= acc_pkg::TRIG_FREE_RUN;
      didrQ    <= 6'h00;
    end else begin
      enQ <= enD;
      if (csWrite) begin
        autoQ <= wdata[acc_pkg::CS_AUTO];
        ieQ   <= wdata[acc_pkg::CS_IRQ_EN];
        divQ  <= wdata[acc_pkg::CS_DIV_MSB:0];
      end
      if (isWrite) begin
        refQ  <= wdata[acc_pkg::IS_REF_MSB:acc_pkg::IS_REF_LSB];
        leftQ <= wdata[acc_pkg::IS_LEFT];
        chQ   <= wdata[acc_pkg::IS_CH_MSB:0];
      end
      // Reserved bits are not stored, so they read zero whatever is written
      if (tsWrite) begin
        trigSelQ <= wdata[2:0];
      end
      if (ddWrite) begin
        didrQ <= wdata[5:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Conversion sequencing
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      busyQ     <= 1'b0;
      initDoneQ <= 1'b0;
      cycLeftQ  <= 5'd0;
      prescQ    <= 7'h00;
      trigPrevQ <= 1'b0;
    end else begin
      prescQ    <= enQ ? 7'(prescQ + 7'h01) : 7'h00;
      trigPrevQ <= srcFlag;
      if (!enD) begin
        busyQ     <= 1'b0;
        initDoneQ <= 1'b0;
      end else if (startConv) begin
        busyQ     <= 1'b1;
        initDoneQ <= 1'b1;
        cycLeftQ  <= initDoneQ ? acc_pkg::CYC_NORMAL : acc_pkg::CYC_FIRST;
      end else if (convDone) begin
        busyQ     <= 1'b0;
      end else if (busyQ && adcTick) begin
        cycLeftQ  <= 5'(cycLeftQ - 5'd1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Applied settings frozen while a conversion runs
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      applRefQ <= acc_pkg::REF_EXTERNAL;
      applChQ  <= 4'h0;
    end else if (!busyQ || convDone) begin
      applRefQ <= refQ;
      applChQ  <= chQ;
    end
  end

  assign converterPower   = enQ;
  assign appliedReference = applRefQ;
  assign appliedChannel   = applChQ;

  //////////////////////////////////////////////////////////////////////////////
  // Result capture, read lock and done flag
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      resultQ <= acc_pkg::RESET_RESULT;
      lockQ   <= 1'b0;
      flagQ   <= 1'b0;
    end else begin
      // Front end already scales the code to input over reference
      if (updResult) begin
        resultQ <= analogCode;
      end
      if (highRead) begin
        lockQ <= 1'b0;
      end else if (lowRead) begin
        lockQ <= 1'b1;
      end
      // Set beats both clears in the same cycle
      flagQ <= updResult |
               (flagQ & ~(doneVectorTaken | (csWrite & wdata[acc_pkg::CS_DONE])));
    end
  end

  assign doneIrq = flagQ & ieQ & globalIrqEnable;

  //////////////////////////////////////////////////////////////////////////////
  // Digital input buffers of the analog pins
  assign pinBufferDisable = didrQ;
  assign portPinRead      = portPinRaw & ~didrQ;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_resvZero;
    @(posedge core_clk) disable iff (!resetn)
      (avsRead && !ackQ && idx == acc_pkg::IDX_INPUT_SEL) |=> !avsReaddata[4];
  endproperty
  a_resvZero: assert property (p_resvZero) else $error("reserved select bit read one");

  property p_abort;
    @(posedge core_clk) disable iff (!resetn)
      (csWrite && !wdata[acc_pkg::CS_ENABLE]) |=> !busyQ && !converterPower;
  endproperty
  a_abort: assert property (p_abort) else $error("disable did not abort conversion");

  property p_firstLen;
    @(posedge core_clk) disable iff (!resetn)
      (startConv && !initDoneQ) |=> busyQ && cycLeftQ == 5'd25;
  endproperty
  a_firstLen: assert property (p_firstLen) else $error("first conversion length wrong");

  property p_laterLen;
    @(posedge core_clk) disable iff (!resetn)
      (startConv && initDoneQ) |=> busyQ && cycLeftQ == 5'd13;
  endproperty
  a_laterLen: assert property (p_laterLen) else $error("conversion length wrong");

  property p_swStart;
    @(posedge core_clk) disable iff (!resetn)
      (swStart && wdata[acc_pkg::CS_ENABLE] && !busyQ) |=> busyQ ##1 csRead[acc_pkg::CS_START];
  endproperty
  a_swStart: assert property (p_swStart) else $error("start write did not begin");

  property p_flagSet;
    @(posedge core_clk) disable iff (!resetn)
      (convDone && !lockQ) |=> flagQ && resultQ == $past(analogCode);
  endproperty
  a_flagSet: assert property (p_flagSet) else $error("completion did not set flag");

  property p_flagClr;
    @(posedge core_clk) disable iff (!resetn)
      (doneVectorTaken && !updResult) |=> !flagQ;
  endproperty
  a_flagClr: assert property (p_flagClr) else $error("vector did not clear flag");

  property p_irq;
    @(posedge core_clk) disable iff (!resetn)
      (flagQ && ieQ && globalIrqEnable) |-> doneIrq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request missing");

  property p_lock;
    @(posedge core_clk) disable iff (!resetn)
      (lockQ && !highRead) |=> $stable(resultQ);
  endproperty
  a_lock: assert property (p_lock) else $error("locked result changed");

  property p_frozen;
    @(posedge core_clk) disable iff (!resetn)
      (busyQ && $past(busyQ) && !$past(convDone)) |-> $stable(applChQ) && $stable(applRefQ);
  endproperty
  a_frozen: assert property (p_frozen) else $error("settings changed mid conversion");

  property p_divide;
    @(posedge core_clk) disable iff (!resetn)
      (adcTick && divQ > 3'h1 && $stable(divQ)) |=> !adcTick;
  endproperty
  a_divide: assert property (p_divide) else $error("prescaler tick too soon");

  property p_freeRun;
    @(posedge core_clk) disable iff (!resetn)
      (convDone && enQ && autoQ && freeRun && !csWrite) |=> busyQ;
  endproperty
  a_freeRun: assert property (p_freeRun) else $error("free running did not restart");

  property p_zeroStart;
    @(posedge core_clk) disable iff (!resetn)
      (csWrite && wdata[acc_pkg::CS_ENABLE] && !wdata[acc_pkg::CS_START] && busyQ && !convDone) |=> busyQ;
  endproperty
  a_zeroStart: assert property (p_zeroStart) else $error("zero start stopped conversion");

  property p_trigEdge;
    @(posedge core_clk) disable iff (!resetn)
      (enQ && enD && autoQ && !freeRun && srcFlag && !trigPrevQ && !busyQ) |=> busyQ;
  endproperty
  a_trigEdge: assert property (p_trigEdge) else $error("trigger edge did not start");

  property p_freeSelect;
    @(posedge core_clk) disable iff (!resetn)
      (tsWrite && wdata[2:0] == acc_pkg::TRIG_FREE_RUN && !busyQ && !autoStart) |=> !busyQ;
  endproperty
  a_freeSelect: assert property (p_freeSelect) else $error("free running select started conversion");

  property p_irqOff;
    @(posedge core_clk) disable iff (!resetn)
      !(flagQ && ieQ && globalIrqEnable) |-> !doneIrq;
  endproperty
  a_irqOff: assert property (p_irqOff) else $error("interrupt request without cause");

  c_done:    cover property (@(posedge core_clk) disable iff (!resetn) convDone);
  c_locked:  cover property (@(posedge core_clk) disable iff (!resetn) convDone && lockQ);
  c_trigger: cover property (@(posedge core_clk) disable iff (!resetn) autoStart && !freeRun);
  c_restart: cover property (@(posedge core_clk) disable iff (!resetn) convDone && startConv);
  c_abort:   cover property (@(posedge core_clk) disable iff (!resetn) busyQ && csWrite && !wdata[acc_pkg::CS_ENABLE]);

endmodule : acc_converter_control

// ---- tb/tb_acc_converter_control.sv ----
// Self-checking bench for the analog converter control block.
// Assumes the register slave answers every request through waitrequest.
`timescale 1ns/1ps

module tb_acc_converter_control;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] LO = acc_pkg::IDX_RESULT_LOW;
  localparam logic [7:0] HI = acc_pkg::IDX_RESULT_HIGH;
  localparam logic [7:0] CS = acc_pkg::IDX_CTRL_STATUS;
  localparam logic [7:0] TC = acc_pkg::IDX_TRIG_CONFIG;
  localparam logic [7:0] IS = acc_pkg::IDX_INPUT_SEL;
  localparam logic [7:0] DD = acc_pkg::IDX_DIG_DISABLE;
  localparam logic [7:0] REG_LIST [6] = '{LO, HI, CS, TC, IS, DD};

  logic        core_clk;
  logic        resetn;
  logic [9:0]  avsAddress;
  logic        avsRead;
  logic        avsWrite;
  logic [31:0] avsWritedata;
  logic [3:0]  avsByteenable;
  logic [31:0] avsReaddata;
  logic        avsWaitrequest;
  logic [9:0]  analogCode;
  logic        converterPower;
  logic [1:0]  appliedReference;
  logic [3:0]  appliedChannel;
  logic [6:0]  triggerFlags;
  logic        globalIrqEnable;
  logic        doneVectorTaken;
  logic        doneIrq;
  logic [5:0]  portPinRaw;
  logic [5:0]  pinBufferDisable;
  logic [5:0]  portPinRead;
  logic [7:0]  rd;
  int          n_mismatch;
  int          num_checks;

  acc_converter_control dut (.core_clk(core_clk), .resetn(resetn), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .analogCode(analogCode), .converterPower(converterPower),
    .appliedReference(appliedReference), .appliedChannel(appliedChannel), .triggerFlags(triggerFlags),
    .globalIrqEnable(globalIrqEnable), .doneVectorTaken(doneVectorTaken), .doneIrq(doneIrq),
    .portPinRaw(portPinRaw), .pinBufferDisable(pinBufferDisable), .portPinRead(portPinRead));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic check_range(input string what, input int lo, input int hi, input int got);
    num_checks++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check_range

  // Entered just after a rising edge; returns one edge after release
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int   k;
    logic w;
    k = 0;
    avsAddress   <= {idx, 2'h0};
    avsWritedata <= {24'h0, wd};
    avsWrite     <= wr;
    avsRead      <= ~wr;
    do begin
      @(negedge core_clk);
      w  = avsWaitrequest;
      rd = avsReaddata[7:0];
      @(posedge core_clk);
      k++;
    end while (w !== 1'b0 && k < 20);
    avsWrite <= 1'b0;
    avsRead  <= 1'b0;
    if (k >= 20) begin
      n_mismatch++;
      $display("BAD bus answer timeout");
      tally_and_finish();
    end
    @(posedge core_clk);
  endtask : bus

  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask : wreg

  task automatic rchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check(what, exp, rd);
  endtask : rchk

  task automatic busy_is(input logic e);
    bus(1'b0, CS, 8'h00);
    check("busy bit", {7'h0, e}, {7'h0, rd[6]});
  endtask : busy_is

  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      bus(1'b0, CS, 8'h00);
      k++;
    end while (rd[6] !== 1'b0 && k < 1000);
    if (k >= 1000) begin
      n_mismatch++;
      $display("BAD idle wait timeout");
      tally_and_finish();
    end
  endtask : wait_idle

  // Tick phase is free running, so the window is one divisor wide
  task automatic timed(input logic [2:0] div, input int ticks);
    int d;
    int k;
    d = (div == 3'h0) ? 2 : (1 << div);
    k = 0;
    wreg(CS, {5'b11001, div});
    do begin
      @(negedge core_clk);
      k++;
    end while (doneIrq !== 1'b1 && k < d * ticks + 8);
    check_range("conversion length", d * (ticks - 1) + 1, d * ticks + 1, k);
    @(posedge core_clk);
  endtask : timed

  task automatic vector_clear;
    doneVectorTaken <= 1'b1;
    @(posedge core_clk);
    doneVectorTaken <= 1'b0;
    @(posedge core_clk);
  endtask : vector_clear

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0; avsAddress = 10'h000; avsRead = 1'b0; avsWrite = 1'b0; avsWritedata = 32'h0;
    avsByteenable = 4'hf; analogCode = 10'h2a5; triggerFlags = 7'h00; globalIrqEnable = 1'b1;
    doneVectorTaken = 1'b0; portPinRaw = 6'h3f; n_mismatch = 0; num_checks = 0;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 6; i++) begin
      rchk("reset value", REG_LIST[i], 8'h00);
    end
    wreg(8'h7d, 8'hff);
    rchk("unmapped", 8'h7d, 8'h00);
    for (int i = 0; i < 16; i++) begin
      wreg(IS, {i[1:0], 2'b01, i[3:0]});
      @(negedge core_clk);
      check("applied channel", {4'h0, i[3:0]}, {4'h0, appliedChannel});
      check("applied reference", {6'h0, i[1:0]}, {6'h0, appliedReference});
      @(posedge core_clk);
      rchk("input select", IS, {i[1:0], 2'b00, i[3:0]});
    end
    wreg(DD, 8'h15);
    @(negedge core_clk);
    check("buffer disable", 8'h15, {2'h0, pinBufferDisable});
    check("pin read", 8'h2a, {2'h0, portPinRead});
    @(posedge core_clk);
    wreg(TC, 8'h07);
    rchk("trigger config", TC, 8'h07);
    // Single conversions, enable and start written together first
    wreg(IS, 8'h43);
    timed(3'h0, 25);
    rchk("result low", LO, 8'ha5);
    rchk("result high", HI, 8'h02);
    rchk("status after done", CS, 8'h98);
    wreg(IS, 8'h63);
    rchk("left low", LO, 8'h40);
    rchk("left high", HI, 8'ha9);
    globalIrqEnable <= 1'b0;
    @(negedge core_clk);
    check("irq gated", 8'h00, {7'h0, doneIrq});
    @(posedge core_clk);
    globalIrqEnable <= 1'b1;
    vector_clear();
    rchk("flag after vector", CS, 8'h88);
    wreg(IS, 8'h43);
    timed(3'h1, 13);
    wreg(CS, 8'h99);
    rchk("flag after write one", CS, 8'h89);
    // Busy, ignored zero start, held channel, then abort
    wreg(CS, 8'hcf);
    rchk("busy status", CS, 8'hcf);
    wreg(CS, 8'h8f);
    rchk("zero start ignored", CS, 8'hcf);
    wreg(IS, 8'h47);
    @(negedge core_clk);
    check("channel held", 8'h03, {4'h0, appliedChannel});
    @(posedge core_clk);
    wreg(CS, 8'h0f);
    @(negedge core_clk);
    check("power off", 8'h00, {7'h0, converterPower});
    @(posedge core_clk);
    rchk("aborted", CS, 8'h0f);
    wreg(CS, 8'h80);
    timed(3'h2, 25);
    @(negedge core_clk);
    check("channel applied", 8'h07, {4'h0, appliedChannel});
    @(posedge core_clk);
    vector_clear();
    timed(3'h7, 13);
    vector_clear();
    // Low byte read holds the pair until the high byte is read
    wreg(IS, 8'h43);
    rchk("locked low", LO, 8'ha5);
    analogCode <= 10'h15a;
    wreg(CS, 8'hc0);
    wait_idle();
    rchk("locked high", HI, 8'h02);
    wreg(CS, 8'hc0);
    wait_idle();
    rchk("new low", LO, 8'h5a);
    rchk("new high", HI, 8'h01);
    // Auto trigger from every source code
    wreg(CS, 8'ha0);
    for (int k = 1; k < 8; k++) begin
      wreg(TC, k[7:0]);
      triggerFlags <= 7'h01 << (k - 1);
      repeat (2) @(posedge core_clk);
      busy_is(1'b1);
      wait_idle();
      triggerFlags <= 7'h00;
      repeat (2) @(posedge core_clk);
    end
    wreg(CS, 8'h80);
    wreg(TC, 8'h01);
    triggerFlags <= 7'h01;
    repeat (2) @(posedge core_clk);
    busy_is(1'b0);
    wreg(TC, 8'h02);
    wreg(CS, 8'ha0);
    busy_is(1'b0);
    wreg(TC, 8'h01);
    @(posedge core_clk);
    busy_is(1'b1);
    wait_idle();
    wreg(TC, 8'h00);
    busy_is(1'b0);
    wreg(CS, 8'he0);
    repeat (40) @(posedge core_clk);
    rchk("free running restart", CS, 8'hf0);
    wreg(CS, 8'h00);
    rchk("stopped", CS, 8'h10);
    tally_and_finish();
  end

endmodule : tb_acc_converter_control
